/* logic/rxm_pkg.sv */
// constants and types shared by the receive marker extractor
package rxm_pkg;
    // ==========================================
    // character clock division
    localparam logic [3:0] CHAR_DIV_STD  = 4'd10;   // decoded / 10-bit raw
    localparam logic [3:0] CHAR_DIV_WIDE = 4'd12;   // 12-bit raw
    // ==========================================
    // decoded special characters (k flag set)
    localparam logic [7:0] CODE_CELL   = 8'hf7;    // cell-start marker
    localparam logic [7:0] CODE_CMD    = 8'hfb;    // expanded command marker
    localparam logic [7:0] CODE_ADDR   = 8'hfd;    // serial address marker
    localparam logic [7:0] CODE_IB_ON  = 8'h1c;    // in-band rise
    localparam logic [7:0] CODE_IB_OFF = 8'h7c;    // in-band fall
    localparam logic [7:0] CODE_COMMA  = 8'hbc;    // comma fill
    // ==========================================
    // receive store geometry and entry layout
    localparam int         STORE_AW    = 8;
    localparam int         ENTRY_W     = 15;
    localparam logic [8:0] STORE_FULL  = 9'h100;
    localparam logic [8:0] STORE_HALF  = 9'h080;
    localparam int         E_SOC       = 12;       // start-of-cell bit
    localparam int         E_CTRL      = 13;       // control/data bit
    localparam int         E_VIOL      = 14;       // violation bit
    // ==========================================
    // synchronised pin vector positions
    localparam int         PIN_N       = 6;
    localparam int         P_FIFO      = 0;
    localparam int         P_CODEC     = 1;
    localparam int         P_WIDTH     = 2;
    localparam int         P_RDCLK     = 3;
    localparam int         P_AM        = 4;
    localparam int         P_RSEL      = 5;
    // ==========================================
    // register map (byte offsets) and fields
    localparam logic [3:0] OFF_CTRL    = 4'h0;
    localparam logic [3:0] OFF_SADDR   = 4'h4;
    localparam logic [3:0] OFF_STATUS  = 4'h8;
    localparam logic [3:0] OFF_DROP    = 4'hc;
    localparam int         CTRL_UNI    = 0;        // unicast compare
    localparam int         CTRL_FLUSH  = 1;        // empty the store
    localparam logic [9:0] SADDR_RST   = 10'h3ff;  // match all when not unicast
    localparam int         ST_FULL     = 9;
    localparam int         ST_EMPTY    = 10;
    localparam int         ST_HALF     = 11;
    localparam int         ST_INBAND   = 12;
    localparam int         ST_ACCEPT   = 13;
    localparam int         ST_APEND    = 14;
    localparam int         ST_PACKED   = 15;
    localparam int         ST_DECODED  = 16;
endpackage

/* logic/rxm_packer.sv */
// reassembles decoded bytes into 10-bit source words
`timescale 1ns/1ps
module rxm_packer import rxm_pkg::*; (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       clear,
    input  wire logic       in_valid,
    input  wire logic [7:0] in_byte,
    output logic            out_valid,
    output logic [9:0]      out_word
);
    // ==========================================
    // state
    typedef struct packed {
        logic [17:0] acc;   // bits not yet emitted, lsb first
        logic [4:0]  cnt;   // bits held in acc
        logic        vld;   // word ready pulse
        logic [9:0]  word;  // emitted word
    } rxm_pack_t;
    rxm_pack_t s_reg;
    rxm_pack_t s_next;
    logic [17:0] merged;    // acc with new byte joined
    logic [4:0]  total;     // bit count after join
    assign out_valid = s_reg.vld;
    assign out_word  = s_reg.word;
    // append byte, emit once ten bits are held
    always_comb begin
        s_next = s_reg;
        s_next.vld = 1'b0;
        merged = s_reg.acc | (18'({10'h000, in_byte}) << s_reg.cnt);
        total = s_reg.cnt + 5'd8;
        if (clear) begin
            // special characters other than comma realign the packing boundary
            s_next.acc = 18'h00000;
            s_next.cnt = 5'd0;
        end else if (in_valid) begin
            if (total >= 5'd10) begin
                s_next.vld  = 1'b1;
                s_next.word = merged[9:0];
                s_next.acc  = merged >> 10;
                s_next.cnt  = total - 5'd10;
            end else begin
                s_next.acc = merged;
                s_next.cnt = total;
            end
        end
    end
    // state register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end
endmodule

/* logic/rxm_store.sv */
// receive store: 256 entries, one writer one reader
`timescale 1ns/1ps
module rxm_store import rxm_pkg::*; (
    input  wire logic               hclk,
    input  wire logic               hresetn,
    input  wire logic               flush,
    input  wire logic               wr_en,
    input  wire logic [ENTRY_W-1:0] wr_data,
    input  wire logic               rd_en,
    output logic [ENTRY_W-1:0]      rd_data,
    output logic [8:0]              level
);
    // ==========================================
    // state
    typedef struct packed {
        logic [STORE_AW-1:0] wp;   // write pointer
        logic [STORE_AW-1:0] rp;   // read pointer
        logic [8:0]          lvl;  // entries held
    } rxm_store_t;
    rxm_store_t         s_reg;
    rxm_store_t         s_next;
    logic [ENTRY_W-1:0] mem [0:(1<<STORE_AW)-1];  // character storage
    logic               do_wr;                     // accepted write
    logic               do_rd;                     // accepted read
    assign rd_data = mem[s_reg.rp];
    assign level   = s_reg.lvl;
    assign do_wr   = wr_en && (s_reg.lvl != STORE_FULL);
    assign do_rd   = rd_en && (s_reg.lvl != 9'h000);
    // pointer and level update
    always_comb begin
        s_next = s_reg;
        if (flush) begin
            s_next = '0;
        end else begin
            if (do_wr) begin
                s_next.wp = s_reg.wp + 8'h01;
            end
            if (do_rd) begin
                s_next.rp = s_reg.rp + 8'h01;
            end
            s_next.lvl = s_reg.lvl + 9'(do_wr) - 9'(do_rd);
        end
    end
    // storage array, no reset needed
    always_ff @(posedge hclk) begin
        if (do_wr && !flush) begin
            mem[s_reg.wp] <= wr_data;
        end
    end
    // state register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end
endmodule

/* logic/rxm_receiver.sv */
// receive control: marker extraction, addressing, store and host read
//
// Operation
// - both selects high: store and decoder active
// - decoded store write rate: bit clock over ten
// - host reads on its clock when addressed, selected
// - host read up to 50 MHz; full drops
// - cell marker: next char soc high
// - command marker: next char soc, ctrl high
// - address marker: next data char is address
// - multicast: any common bit opens the gate
// - unicast: exact match gates until next address marker
// - in-band codes drive signal high or low
// - width select low: bytes packed into 10 bits
// - packing only while the store is enabled
// - packed commands carry ten-bit codes
// - packed address register and field ten bits
// - undecoded: every raw char stored, ten/twelve
// - decoded entry: data, violation, control bits
`timescale 1ns/1ps
module rxm_receiver import rxm_pkg::*; (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        fifo_skip_n,
    input  wire logic        codec_skip_n,
    input  wire logic        char_width_select,
    input  wire logic        host_read_clock,
    input  wire logic        addr_match_strobe_n,
    input  wire logic        read_select_n,
    input  wire logic        rx_bit_tick,
    input  wire logic [7:0]  dec_data,
    input  wire logic        dec_special,
    input  wire logic        dec_violation,
    input  wire logic [11:0] raw_char,
    output logic [11:0]      output_char_bus,
    output logic             cell_start_bit,
    output logic             ctrl_or_data_bit,
    output logic             violation_bit,
    output logic             rx_store_full_n,
    output logic             rx_store_empty_n,
    output logic             rx_store_half_n,
    output logic             inband_signal_out
);
    // ==========================================
    // state
    typedef struct packed {
        logic [PIN_N-1:0] pin_s1;    // pin sync, first stage
        logic [PIN_N-1:0] pin_s2;    // pin sync, second stage
        logic             rdclk_d;   // delayed host clock level
        logic [3:0]       div_cnt;   // bit ticks within char
        logic             mark_soc;  // next unit gets soc
        logic             mark_cmd;  // next unit is a command
        logic             addr_pend; // next unit is an address
        logic             accept;    // address gate open
        logic             inband;    // in-band signal level
        logic [11:0]      out_char;  // presented character
        logic             out_soc;
        logic             out_ctrl;
        logic             out_viol;
        logic             full_n;
        logic             empty_n;
        logic             half_n;
        logic             unicast;   // compare mode
        logic [9:0]       ser_addr;  // serial address register
        logic [15:0]      drops;     // characters lost to full
        logic             flush;     // store flush pulse
        logic             ap_valid;  // ahb data phase pending
        logic             ap_write;
        logic [3:0]       ap_off;    // ahb byte offset
        logic [31:0]      rdata;
    } rxm_state_t;
    rxm_state_t s_reg;
    rxm_state_t s_next;
    // ==========================================
    // helpers
    // decode of a register offset to its read value
    function automatic logic [31:0] reg_read(
        input rxm_state_t s,
        input logic [3:0] off,
        input logic [8:0] lvl,
        input logic       pk,
        input logic       dc
    );
        logic [31:0] v;
        v = 32'h00000000;
        case (off)
            OFF_CTRL:   v[CTRL_UNI] = s.unicast;
            OFF_SADDR:  v[9:0] = s.ser_addr;
            OFF_STATUS: begin
                v[8:0]       = lvl;
                v[ST_FULL]   = (lvl == STORE_FULL);
                v[ST_EMPTY]  = (lvl == 9'h000);
                v[ST_HALF]   = (lvl >= STORE_HALF);
                v[ST_INBAND] = s.inband;
                v[ST_ACCEPT] = s.accept;
                v[ST_APEND]  = s.addr_pend;
                v[ST_PACKED] = pk;
                v[ST_DECODED] = dc;
            end
            OFF_DROP:   v[15:0] = s.drops;
            default:    v = 32'h00000000;
        endcase
        return v;
    endfunction
    // ==========================================
    // sub-block wiring
    logic               fifo_en;     // store enabled
    logic               decoded;     // decoder enabled
    logic               packed_md;   // byte-packed mode
    logic [3:0]         div_max;     // last tick of a char
    logic               char_tick;   // one character complete
    logic               is_marker;   // consumed special char
    logic               byte_data;   // plain data byte arrives
    logic               pk_clear;    // packer realign
    logic               pk_valid;
    logic [9:0]         pk_word;
    logic               unit_valid;  // data unit ready
    logic [9:0]         unit;        // 8- or 10-bit data unit
    logic               addr_hit;    // address compare result
    logic               match_all;   // register says accept all
    logic               wr_en;
    logic [ENTRY_W-1:0] wr_data;
    logic               rd_en;
    logic [ENTRY_W-1:0] rd_data;
    logic [8:0]         level;
    logic               ap_take;     // ahb address phase taken
    // outputs straight from the state register; hreadyout and hresp tied constant
    assign hreadyout         = 1'b1;
    assign hresp             = 1'b0;
    assign hrdata            = s_reg.rdata;
    assign output_char_bus   = s_reg.out_char;
    assign cell_start_bit    = s_reg.out_soc;
    assign ctrl_or_data_bit  = s_reg.out_ctrl;
    assign violation_bit     = s_reg.out_viol;
    assign rx_store_full_n   = s_reg.full_n;
    assign rx_store_empty_n  = s_reg.empty_n;
    assign rx_store_half_n   = s_reg.half_n;
    assign inband_signal_out = s_reg.inband;
    // ==========================================
    // mode decode from synchronised selects
    always_comb begin
        fifo_en   = s_reg.pin_s2[P_FIFO];
        decoded   = s_reg.pin_s2[P_CODEC];
        packed_md = fifo_en && decoded && !s_reg.pin_s2[P_WIDTH];
        match_all = !s_reg.unicast && (s_reg.ser_addr == SADDR_RST);
    end
    // ==========================================
    // character clock: bit ticks divided down
    always_comb begin
        div_max = (!decoded && !s_reg.pin_s2[P_WIDTH]) ? CHAR_DIV_WIDE - 4'd1 : CHAR_DIV_STD - 4'd1;
        char_tick = rx_bit_tick && (s_reg.div_cnt >= div_max);
    end
    // ==========================================
    // special character classification
    always_comb begin
        is_marker = 1'b0;
        if (decoded && dec_special) begin
            case (dec_data)
                CODE_CELL, CODE_CMD, CODE_ADDR,
                CODE_IB_ON, CODE_IB_OFF, CODE_COMMA:
                    is_marker = 1'b1;
                default:
                    is_marker = 1'b0;
            endcase
        end
        byte_data = char_tick && decoded && !dec_special;
        pk_clear  = char_tick && decoded && dec_special
                    && (dec_data != CODE_COMMA);
    end
    // data unit: a byte, or a packed ten-bit word
    always_comb begin
        unit_valid = packed_md ? pk_valid : byte_data;
        unit       = packed_md ? pk_word : {2'b00, dec_data};
    end
    // address compare at the unit width, top two bits only when packed
    always_comb begin
        if (s_reg.unicast) begin
            addr_hit = ((unit ^ s_reg.ser_addr) & {{2{packed_md}}, 8'hff}) == 10'h000;
        end else begin
            addr_hit = |(unit & s_reg.ser_addr & {{2{packed_md}}, 8'hff});
        end
    end
    // ==========================================
    // store write selection
    always_comb begin
        wr_en   = 1'b0;
        wr_data = '0;
        if (fifo_en && !decoded) begin
            // raw characters all go in
            wr_en   = char_tick;
            wr_data = {3'b000, raw_char};
        end else if (fifo_en && decoded) begin
            if (char_tick && dec_special && !is_marker
                    && (s_reg.accept || match_all)) begin
                // other control codes kept as control
                wr_en   = 1'b1;
                wr_data = {dec_violation, 1'b1, 1'b0, 4'h0, dec_data};
            end else if (unit_valid && !s_reg.addr_pend
                    && (s_reg.accept || match_all)) begin
                wr_en = 1'b1;
                if (s_reg.mark_cmd) begin
                    wr_data = {1'b0, 1'b1, 1'b1, 2'b00, unit};
                end else if (s_reg.mark_soc) begin
                    wr_data = {1'b0, 1'b0, 1'b1, 2'b00, unit};
                end else begin
                    wr_data = {dec_violation && !packed_md, 1'b0, 1'b0,
                               2'b00, unit};
                end
            end
        end
    end
    // host read: rising host clock while addressed and selected
    always_comb begin
        rd_en = fifo_en
                && s_reg.pin_s2[P_RDCLK] && !s_reg.rdclk_d
                && !s_reg.pin_s2[P_AM] && !s_reg.pin_s2[P_RSEL]
                && (level != 9'h000);
        ap_take = hsel && hready && htrans[1];
    end
    // ==========================================
    // next state
    always_comb begin
        s_next = s_reg;
        s_next.flush  = 1'b0;
        // pin synchronisers
        s_next.pin_s1  = {read_select_n, addr_match_strobe_n,
                          host_read_clock, char_width_select,
                          codec_skip_n, fifo_skip_n};
        s_next.pin_s2  = s_reg.pin_s1;
        s_next.rdclk_d = s_reg.pin_s2[P_RDCLK];
        // bit tick counter
        if (char_tick) begin
            s_next.div_cnt = 4'd0;
        end else if (rx_bit_tick) begin
            s_next.div_cnt = s_reg.div_cnt + 4'd1;
        end
        // marker handling on decoded characters
        if (char_tick && decoded && dec_special) begin
            case (dec_data)
                CODE_CELL: begin
                    s_next.mark_soc = 1'b1;
                    s_next.mark_cmd = 1'b0;
                end
                CODE_CMD: begin
                    s_next.mark_cmd = 1'b1;
                    s_next.mark_soc = 1'b0;
                end
                CODE_ADDR: begin
                    s_next.addr_pend = 1'b1;
                    s_next.accept    = 1'b0;
                end
                CODE_IB_ON:  s_next.inband = 1'b1;
                CODE_IB_OFF: s_next.inband = 1'b0;
                default: begin
                    // other specials except comma cancel a pending marker
                    if (dec_data != CODE_COMMA) begin
                        s_next.mark_soc = 1'b0;
                        s_next.mark_cmd = 1'b0;
                    end
                end
            endcase
        end
        // data unit consumes pending marker or address
        if (unit_valid) begin
            if (s_reg.addr_pend) begin
                s_next.addr_pend = 1'b0;
                s_next.accept    = addr_hit;
            end
            s_next.mark_soc = 1'b0;
            s_next.mark_cmd = 1'b0;
        end
        // characters lost while the store is full
        if (wr_en && (level == STORE_FULL)) begin
            s_next.drops = s_reg.drops + 16'h0001;
        end
        // presented character on host read
        if (rd_en) begin
            s_next.out_char = rd_data[11:0];
            s_next.out_soc  = rd_data[E_SOC];
            s_next.out_ctrl = rd_data[E_CTRL];
            s_next.out_viol = rd_data[E_VIOL];
        end
        // status flags, active low
        s_next.full_n  = !(level == STORE_FULL);
        s_next.empty_n = (level != 9'h000);
        s_next.half_n  = !(level >= STORE_HALF);
        // ahb address phase
        s_next.ap_valid = ap_take;
        if (ap_take) begin
            s_next.ap_write = hwrite;
            s_next.ap_off   = haddr[3:0];
            s_next.rdata    = reg_read(s_reg, haddr[3:0], level,
                                       packed_md, decoded);
        end
        // ahb data phase write
        if (s_reg.ap_valid && s_reg.ap_write) begin
            case (s_reg.ap_off)
                OFF_CTRL: begin
                    s_next.unicast = hwdata[CTRL_UNI];
                    s_next.flush   = hwdata[CTRL_FLUSH];
                end
                OFF_SADDR: begin
                    s_next.ser_addr = hwdata[9:0];
                    s_next.accept   = 1'b0;
                end
                OFF_DROP: begin
                    // a loss in the same cycle still counts
                    s_next.drops = 16'(wr_en && (level == STORE_FULL));
                end
                default: s_next.flush = 1'b0;
            endcase
        end
    end
    // ==========================================
    // sub-blocks
    // bytes to ten-bit words in packed mode
    rxm_packer u_packer (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .clear     (pk_clear),
        .in_valid  (byte_data && packed_md),
        .in_byte   (dec_data),
        .out_valid (pk_valid),
        .out_word  (pk_word)
    );
    // receive store
    rxm_store u_store (
        .hclk    (hclk),
        .hresetn (hresetn),
        .flush   (s_reg.flush),
        .wr_en   (wr_en),
        .wr_data (wr_data),
        .rd_en   (rd_en),
        .rd_data (rd_data),
        .level   (level)
    );
    // ==========================================
    // state register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_reg          <= '0;
            s_reg.full_n   <= 1'b1;
            s_reg.half_n   <= 1'b1;
            s_reg.ser_addr <= SADDR_RST;
        end else begin
            s_reg <= s_next;
        end
    end
endmodule

/* bench/rxm_sva.sv */
// port checker for the receive marker extractor
`timescale 1ns/1ps
module rxm_sva import rxm_pkg::*; (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hresp,
    input wire logic        addr_match_strobe_n,
    input wire logic        read_select_n,
    input wire logic [7:0]  dec_data,
    input wire logic        dec_special,
    input wire logic [11:0] output_char_bus,
    input wire logic        cell_start_bit,
    input wire logic        violation_bit,
    input wire logic        rx_store_full_n,
    input wire logic        rx_store_empty_n,
    input wire logic        rx_store_half_n,
    input wire logic        inband_signal_out
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ==========================================
    // store flags, host reads, marker effects
    bus_okay_a: assert property (!hresp) else $error("error response");
    full_flags_a: assert property (!rx_store_full_n |-> rx_store_empty_n && !rx_store_half_n) else $error("full");
    empty_half_a: assert property (!rx_store_empty_n |-> rx_store_half_n) else $error("empty yet half");
    unaddr_hold_a: assert property (addr_match_strobe_n [*7] |-> $stable(output_char_bus)) else $error("read");
    unsel_hold_a: assert property (read_select_n [*7] |-> $stable(output_char_bus)) else $error("read");
    cell_clean_a: assert property (cell_start_bit |-> !violation_bit) else $error("cell entry flagged");
    ib_rise_a: assert property ($rose(inband_signal_out) |-> $past(dec_special) &&
        $past(dec_data) == CODE_IB_ON) else $error("in-band rose");
    ib_fall_a: assert property ($fell(inband_signal_out) |-> $past(dec_special) &&
        $past(dec_data) == CODE_IB_OFF) else $error("in-band fell");
endmodule
bind rxm_receiver rxm_sva chk_i (.hclk, .hresetn, .hresp, .addr_match_strobe_n, .read_select_n, .dec_data,
    .dec_special, .output_char_bus, .cell_start_bit, .violation_bit, .rx_store_full_n, .rx_store_empty_n,
    .rx_store_half_n, .inband_signal_out);

/* bench/rxm_link_model.sv */
// remote transmitter model: one decoded character per ten bit ticks
`timescale 1ns/1ps
module rxm_link_model import rxm_pkg::*; (
    output logic        rx_bit_tick,
    output logic [7:0]  dec_data,
    output logic        dec_special,
    output logic        dec_violation,
    output logic [11:0] raw_char,
    input  wire logic   hclk,
    input  wire logic   hresetn
);
    logic [8:0] q[$];  // pending characters, special flag on top
    int         w;     // settle count after reset
    int         n;     // bit ticks into the character
    task automatic send(input logic [8:0] c);
        q.push_back(c);
    endtask
    // tick every other cycle, a character held for ten ticks
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            w <= 0;
            n <= 0;
            rx_bit_tick <= 1'h0;
            {dec_special, dec_data} <= {1'h1, CODE_COMMA};
        end else if (w < 4) begin
            w <= w + 1;
        end else begin
            rx_bit_tick <= ~rx_bit_tick;
            if (rx_bit_tick) begin
                n <= (n == 9) ? 0 : n + 1;
                // idle link carries comma fill
                if (n == 9) {dec_special, dec_data} <= (q.size() != 0) ? q.pop_front() : {1'h1, CODE_COMMA};
            end
        end
    end
    assign dec_violation = 1'h0;
    assign raw_char = {3'h0, dec_special, dec_data};
endmodule

/* bench/rx_fifo_marker_extractor_test.sv */
// self-checking bench for the receive marker extractor
`timescale 1ns/1ps
module rx_fifo_marker_extractor_test import rxm_pkg::*;;
    logic        hclk, hresetn, hsel, hwrite, hready, host_read_clock, addr_match_strobe_n, read_select_n;
    logic        rx_bit_tick, dec_special, dec_violation, cell_start_bit, ctrl_or_data_bit, violation_bit;
    logic        rx_store_empty_n, inband_signal_out, char_width_select;
    logic [1:0]  htrans;
    logic [7:0]  dec_data;
    logic [11:0] raw_char, output_char_bus;
    logic [31:0] haddr, hwdata, hrdata, rd;
    int          mismatches = 0;
    int          checks_done = 0;
    logic [11:0] exp_e[7] = '{12'h45a, 12'hca5, 12'h033, 12'h066, 12'h077, 12'h078, 12'hfff}; // ctrl, soc, data
    rxm_receiver dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready,
        .hreadyout(hready), .hresp(), .hrdata, .fifo_skip_n(1'h1), .codec_skip_n(1'h1), .char_width_select,
        .host_read_clock, .addr_match_strobe_n, .read_select_n, .rx_bit_tick, .dec_data, .dec_special,
        .dec_violation, .raw_char, .output_char_bus, .cell_start_bit, .ctrl_or_data_bit, .violation_bit,
        .rx_store_full_n(), .rx_store_empty_n, .rx_store_half_n(), .inband_signal_out);
    rxm_link_model link (.hclk, .hresetn, .rx_bit_tick, .dec_data, .dec_special, .dec_violation, .raw_char);
    initial begin
        hclk = 1'h0;
        forever #2.5 hclk = ~hclk;
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one single AHB transfer, read data left in rd
    task automatic ahb(input logic w, input logic [3:0] a, input logic [31:0] wd);
        hsel <= 1'h1;
        htrans <= 2'h2;
        haddr <= {28'h0, a};
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'h1);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'h1);
        rd = hrdata;
    endtask
    // send characters, then let the link finish them
    task automatic push(input logic [8:0] c[$]);
        foreach (c[i]) link.send(c[i]);
        wait (link.q.size() == 0);
        repeat (40) @(posedge hclk);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        {hsel, hwrite, host_read_clock, hresetn, htrans, haddr, hwdata} = '0;
        {char_width_select, addr_match_strobe_n, read_select_n} = 3'h7;
        repeat (16) @(posedge hclk);
        hresetn <= 1'h1;
        @(posedge hclk);
        ahb(1'h0, OFF_SADDR, 32'h0);
        chk("saddr", rd, 32'h3ff);
        push('{{1'h1, CODE_CELL}, 9'h05a, {1'h1, CODE_CMD}, 9'h0a5, 9'h033, {1'h1, CODE_IB_ON}});
        chk("inband", inband_signal_out, 32'h1);
        push('{{1'h1, CODE_IB_OFF}});
        chk("inband", inband_signal_out, 32'h0);
        ahb(1'h1, OFF_SADDR, 32'h1);
        push('{{1'h1, CODE_ADDR}, 9'h002, 9'h044, {1'h1, CODE_ADDR}, 9'h003, 9'h066});
        ahb(1'h1, OFF_CTRL, 32'h1);
        ahb(1'h1, OFF_SADDR, 32'h12);
        {addr_match_strobe_n, read_select_n} <= 2'h0;
        push('{{1'h1, CODE_ADDR}, 9'h012, 9'h077, 9'h078, {1'h1, CODE_ADDR}, 9'h013, 9'h099});
        char_width_select <= 1'h0;
        push('{{1'h1, CODE_ADDR}, 9'h012, 9'h000, {1'h1, CODE_CMD}, 9'h0ff, 9'h003});
        $display("test stream done");
        for (int i = 0; i < 7; i++) begin
            host_read_clock <= 1'h1;
            repeat (4) @(posedge hclk);
            host_read_clock <= 1'h0;
            repeat (6) @(posedge hclk);
            chk("data", output_char_bus, exp_e[i][9:0]);
            chk("soc", cell_start_bit, exp_e[i][10]);
            chk("ctl", ctrl_or_data_bit, exp_e[i][11]);
        end
        chk("empty_n", rx_store_empty_n, 32'h0);
        $display("test reads done");
        tally_and_finish();
    end
    initial begin
        repeat (20000) @(posedge hclk);
        mismatches++;
        tally_and_finish();
    end
endmodule
